// [rtl/frp_pkg.sv]
// Purpose: shared constants and bus carriers for the flash read path block
// Assumes: AHB-Lite transfers of whole words; word bursts on the high-speed port, single transfers on the peripheral port
// Notes: register offsets are byte addresses on the peripheral port
package frp_pkg;
	localparam int PG_DW = 32; // doublewords per page and page buffer
	localparam int REGIONS = 16;
	localparam logic [1:0] TR_NONSEQ = 2'h2;
	localparam logic [1:0] TR_SEQ = 2'h3;
	localparam logic [23:0] USER_OFS = 24'h800000;
	localparam int USER_BIT = 23;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam int CTL_WS = 0;
	localparam int CTL_SEQ = 1;
	localparam int CTL_LOOP = 2;
	localparam int CMD_LSB = 0;
	localparam int PAGE_LSB = 8;
	localparam int ST_RDY = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_QRES = 5;
	localparam logic [2:0] CTL_RST = 3'h0;
	localparam int WR_WS = 4; // stall cycles of a page buffer write
	localparam logic [3:0] C_CLR_PB = 4'h1;
	localparam logic [3:0] C_WR_PG = 4'h2;
	localparam logic [3:0] C_ER_PG = 4'h3;
	localparam logic [3:0] C_ER_ALL = 4'h4;
	localparam logic [3:0] C_WR_UP = 4'h5;
	localparam logic [3:0] C_ER_UP = 4'h6;
	localparam logic [3:0] C_QPG = 4'h7;
	localparam logic [3:0] C_QUP = 4'h8;
	typedef enum logic [0:0] {
		CS_IDLE = 1'b0,
		CS_RUN = 1'b1
	} frp_cmd_e;
	typedef struct packed {
		logic hsel;
		logic [1:0] htrans;
		logic [31:0] haddr;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} frp_ahb_req_s;
	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} frp_ahb_rsp_s;
endpackage

// [rtl/frp_flash_ctl.sv]
// Purpose: flash read path, page buffer and quick page checks
// Assumes: one clock; flash array and user page held in flip-flops
// Notes: hs port serves reads and page buffer writes, pb port registers
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// Functional notes
// RQ1: clock enable low freezes every flop; resumes unchanged when it returns.
// RQ2: no debug input; behaviour never depends on processor debug state.
// RQ3: two bus ports: high-speed for flash/page buffer, peripheral for registers.
// RQ4: array is pages grouped into 16 equal regions, each fuse-protectable; here only RGN_PG is computed, with no protection logic.
// RQ5: zero wait mode returns every read word without stall.
// RQ6: reads fetch a 64-bit location; companion word serves the next read.
// RQ7: control field picks zero or one wait state; software picks correctly.
// RQ8: one wait mode stalls the first access of every transfer once.
// RQ9: unaligned burst start stalls the second word once more.
// RQ10: sequential and loop buffer enable bits turn their buffers on.
// RQ11: both buffers unused in zero wait mode.
// RQ12: reads between array end and user page are undefined.
// RQ13: user page at offset 0x00800000, one page; main array at 0.
// RQ14: user page reads like flash; only its own commands alter it.
// RQ15: quick page check ANDs all bits of a page into result bit.
// RQ16: quick user page check ANDs user page into same result bit.
// RQ17: write to A updates buffer slot A mod 32 and page field A/32.
// RQ18: two word writes merge into one doubleword, low word first.
// RQ19: page buffer takes aligned words only and is never readable.
// RQ20: page buffer write takes 4 wait states, stalling other accesses.
// RQ21: page buffer writes only clear bits.
// RQ22: page buffer kept after a page write; only its clear command sets bits.
// RQ23: flash reads stall while a command runs.
// RQ24: command write clears ready at once; completion sets it again.
// RQ25: reset selects zero wait states with both buffers off.
module frp_flash_ctl #(
	parameter int NUM_PAGES = 16,
	parameter int LOOP_ENT = 4
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire frp_pkg::frp_ahb_req_s hs_in,
	output frp_pkg::frp_ahb_rsp_s hs_out,
	input wire frp_pkg::frp_ahb_req_s pb_in,
	output frp_pkg::frp_ahb_rsp_s pb_out
);
	import frp_pkg::*;
	localparam int NDW = NUM_PAGES * PG_DW;
	localparam int AW = $clog2(NDW);
	localparam int PW = $clog2(NUM_PAGES);
	localparam int BW = $clog2(PG_DW);
	localparam int TW = AW + 1;
	localparam int LW = (LOOP_ENT > 1) ? $clog2(LOOP_ENT) : 1;
	localparam int RGN_PG = (NUM_PAGES >= REGIONS) ? NUM_PAGES / REGIONS : 1; // [RQ4] pages per lock region

	logic [63:0] mem_r [NDW];
	logic [63:0] up_r [PG_DW];
	logic [63:0] pbuf_r [PG_DW];
	logic [2:0] ctl_r;
	logic [3:0] cmd_r;
	logic [PW-1:0] page_r;
	logic ready_r, pend_r, qres_r, qacc_r;
	frp_cmd_e cst_r;
	logic [AW-1:0] cnt_r;
	logic ro_r, dp_r, dpw_r, sec_r, unal_r;
	logic [31:0] rd_r, dpa_r, lo_r;
	logic [2:0] wcnt_r;
	logic lov_r, lastv_r;
	logic [TW-1:0] last_r;
	logic [TW-1:0] ltag_r [LOOP_ENT];
	logic [LOOP_ENT-1:0] lval_r;
	logic [LW-1:0] lptr_r;
	logic pro_r, pwr_r;
	logic [31:0] prd_r;
	logic [7:0] pwa_r;

	// flash word at a bus address; reserved gap reads zero, page buffer never read
	function automatic logic [31:0] word_at(input logic [31:0] a); // [RQ12] [RQ19]
		logic [63:0] d;
		d = 64'h0;
		if (a[USER_BIT] && a[22:0] < 23'(PG_DW * 8))
			d = up_r[a[BW+2:3]]; // [RQ13] [RQ14]
		else if (!a[USER_BIT] && a[22:0] < 23'(NDW * 8))
			d = mem_r[a[AW+2:3]];
		return a[2] ? d[63:32] : d[31:0]; // [RQ6]
	endfunction

	function automatic logic [TW-1:0] tag_of(input logic [31:0] a);
		return {a[USER_BIT], a[AW+2:3]};
	endfunction

	logic av, rd_av, wr_av, ws1, run, hs_idle, start, done;
	logic seq_hit, loop_hit, buf_hit, stall1;
	logic [AW-1:0] walk_a, last_cnt;
	assign av = hs_in.hsel && hs_in.htrans[1] && hs_in.hready && ro_r;
	assign rd_av = av && !hs_in.hwrite;
	assign wr_av = av && hs_in.hwrite;
	assign ws1 = ctl_r[CTL_WS]; // [RQ7]
	assign run = (cst_r == CS_RUN);
	assign hs_idle = ro_r && !av;
	// a command starts only in a cycle with the high-speed port ready and no high-speed request
	assign start = pend_r && hs_idle && !run;
	assign last_cnt = (cmd_r == C_ER_ALL) ? AW'(NDW - 1) : AW'(PG_DW - 1);
	assign done = run && cnt_r == last_cnt;
	assign walk_a = AW'({page_r, cnt_r[BW-1:0]});
	// buffers only take part in one wait mode
	assign seq_hit = ws1 && ctl_r[CTL_SEQ] && lastv_r && last_r == tag_of(hs_in.haddr); // [RQ10] [RQ11]
	always_comb begin
		loop_hit = 1'b0;
		for (int i = 0; i < LOOP_ENT; i++) begin
			if (lval_r[i] && ltag_r[i] == tag_of(hs_in.haddr))
				loop_hit = 1'b1;
		end
		loop_hit = loop_hit && ws1 && ctl_r[CTL_LOOP]; // [RQ10] [RQ11]
	end
	assign buf_hit = seq_hit || loop_hit;
	// first access stalls, unaligned burst start stalls its second word too
	assign stall1 = ws1 && !buf_hit && (hs_in.htrans == TR_NONSEQ || (sec_r && unal_r)); // [RQ8] [RQ9]
	logic [31:0] rd_word;
	logic [AW-1:0] pbw_a;
	assign rd_word = word_at(hs_in.haddr);
	assign pbw_a = dpa_r[AW+2:3];

	// high-speed port; all state waits on ce_in [RQ1] [RQ2] [RQ3]
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ro_r <= 1'b1;
			dp_r <= 1'b0;
			dpw_r <= 1'b0;
			dpa_r <= 32'h0;
			rd_r <= 32'h0;
			wcnt_r <= 3'h0;
			sec_r <= 1'b0;
			unal_r <= 1'b0;
		end else if (ce_in) begin
			if (av) begin
				dp_r <= 1'b1;
				dpw_r <= hs_in.hwrite;
				dpa_r <= hs_in.haddr;
				sec_r <= (hs_in.htrans == TR_NONSEQ);
				if (hs_in.htrans == TR_NONSEQ)
					unal_r <= hs_in.haddr[2];
				if (hs_in.hwrite) begin
					ro_r <= 1'b0;
					wcnt_r <= 3'(WR_WS - 1); // [RQ20]
				end else if (stall1 || run) begin
					ro_r <= 1'b0; // [RQ23]
					wcnt_r <= 3'h0;
				end else begin
					ro_r <= 1'b1;
					rd_r <= word_at(hs_in.haddr); // [RQ5]
				end
			end else if (dp_r && !ro_r) begin
				if (wcnt_r != 3'h0) begin
					wcnt_r <= wcnt_r - 3'h1;
				end else if (dpw_r || !run) begin
					ro_r <= 1'b1; // [RQ20] [RQ23]
					if (!dpw_r)
						rd_r <= word_at(dpa_r);
				end
			end else begin
				dp_r <= 1'b0;
			end
		end
	end

	// companion and loop tags
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lastv_r <= 1'b0;
			last_r <= '0;
			lval_r <= '0;
			lptr_r <= '0;
			for (int i = 0; i < LOOP_ENT; i++)
				ltag_r[i] <= '0;
		end else if (ce_in) begin
			if (start || !ws1) begin
				lastv_r <= 1'b0;
				lval_r <= '0;
			end else if (rd_av) begin
				lastv_r <= 1'b1;
				last_r <= tag_of(hs_in.haddr); // [RQ6]
				// new loop targets take the tag slots in turn
				if (ctl_r[CTL_LOOP] && hs_in.htrans == TR_NONSEQ && !loop_hit) begin
					ltag_r[lptr_r] <= tag_of(hs_in.haddr);
					lval_r[lptr_r] <= 1'b1;
					lptr_r <= (32'(lptr_r) == LOOP_ENT - 1) ? '0 : lptr_r + 1'b1;
				end
			end
		end
	end

	// page buffer writes merge words, commands walk the array
	logic pb_wr;
	logic [BW-1:0] pb_idx;
	// merge lands at the last stall edge of a write
	assign pb_wr = dp_r && dpw_r && !ro_r && wcnt_r == 3'h0;
	assign pb_idx = dpa_r[BW+2:3]; // [RQ17]
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lo_r <= 32'h0;
			lov_r <= 1'b0;
			for (int i = 0; i < PG_DW; i++) begin
				pbuf_r[i] <= '1;
				up_r[i] <= '1;
			end
			for (int i = 0; i < NDW; i++)
				mem_r[i] <= '1;
		end else if (ce_in) begin
			if (pb_wr) begin
				if (!dpa_r[2]) begin
					lo_r <= hs_in.hwdata; // [RQ18]
					lov_r <= 1'b1;
				end else begin
					pbuf_r[pb_idx] <= pbuf_r[pb_idx] & {hs_in.hwdata, lov_r ? lo_r : 32'hffffffff}; // [RQ21]
					lov_r <= 1'b0;
				end
			end
			if (run) begin
				case (cmd_r)
					C_CLR_PB: pbuf_r[cnt_r[BW-1:0]] <= '1; // [RQ22]
					C_WR_PG: mem_r[walk_a] <= mem_r[walk_a] & pbuf_r[cnt_r[BW-1:0]];
					C_ER_PG: mem_r[walk_a] <= '1;
					C_ER_ALL: mem_r[cnt_r] <= '1; // [RQ14]
					C_WR_UP: up_r[cnt_r[BW-1:0]] <= up_r[cnt_r[BW-1:0]] & pbuf_r[cnt_r[BW-1:0]];
					C_ER_UP: up_r[cnt_r[BW-1:0]] <= '1;
					default: ;
				endcase
			end
		end
	end

	// command sequencer
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cst_r <= CS_IDLE;
			cnt_r <= '0;
			qacc_r <= 1'b1;
			qres_r <= 1'b0;
		end else if (ce_in) begin
			case (cst_r)
				CS_IDLE: begin
					if (start) begin
						cst_r <= CS_RUN;
						cnt_r <= '0;
						qacc_r <= 1'b1;
					end
				end
				CS_RUN: begin
					if (cmd_r == C_QPG)
						qacc_r <= qacc_r & (&mem_r[walk_a]); // [RQ15]
					else if (cmd_r == C_QUP)
						qacc_r <= qacc_r & (&up_r[cnt_r[BW-1:0]]); // [RQ16]
					cnt_r <= cnt_r + 1'b1;
					if (done) begin
						cst_r <= CS_IDLE;
						if (cmd_r == C_QPG)
							qres_r <= qacc_r & (&mem_r[walk_a]); // [RQ15]
						else if (cmd_r == C_QUP)
							qres_r <= qacc_r & (&up_r[cnt_r[BW-1:0]]); // [RQ16]
					end
				end
				default: cst_r <= CS_IDLE;
			endcase
		end
	end

	// peripheral register port
	logic pb_av;
	assign pb_av = pb_in.hsel && pb_in.htrans[1] && pb_in.hready;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pro_r <= 1'b1;
			pwr_r <= 1'b0;
			pwa_r <= 8'h0;
			prd_r <= 32'h0;
		end else if (ce_in) begin
			pwr_r <= pb_av && pb_in.hwrite;
			pwa_r <= pb_in.haddr[7:0];
			if (pb_av && !pb_in.hwrite) begin
				case (pb_in.haddr[7:0])
					REG_CTRL: prd_r <= 32'(ctl_r);
					REG_CMD: prd_r <= (32'(page_r) << PAGE_LSB) | (32'(cmd_r) << CMD_LSB);
					REG_STAT: prd_r <= (32'(ready_r) << ST_RDY) | (32'(run) << ST_BUSY) | (32'(qres_r) << ST_QRES);
					default: prd_r <= 32'h0;
				endcase
			end
		end
	end

	// command writes dropped while one is pending or running
	logic cmd_wr;
	assign cmd_wr = pwr_r && pwa_r == REG_CMD && !pend_r && !run;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctl_r <= CTL_RST; // [RQ25]
			cmd_r <= 4'h0;
			page_r <= '0;
			ready_r <= 1'b1;
			pend_r <= 1'b0;
		end else if (ce_in) begin
			if (pwr_r && pwa_r == REG_CTRL)
				ctl_r <= pb_in.hwdata[2:0]; // [RQ7] [RQ10]
			if (cmd_wr) begin
				cmd_r <= pb_in.hwdata[CMD_LSB+3:CMD_LSB];
				page_r <= pb_in.hwdata[PAGE_LSB+PW-1:PAGE_LSB];
				pend_r <= 1'b1;
				ready_r <= 1'b0; // [RQ24]
			end else if (wr_av && !run) begin
				page_r <= hs_in.haddr[AW+2:BW+3]; // [RQ17]
			end
			if (start)
				pend_r <= 1'b0;
			if (done)
				ready_r <= 1'b1; // [RQ24]
		end
	end

	assign hs_out = '{hreadyout: ro_r, hresp: 1'b0, hrdata: rd_r};
	assign pb_out = '{hreadyout: pro_r, hresp: 1'b0, hrdata: prd_r};

	// checks: read and page buffer write timing, buffer clearing
	sequence s_one_stall;
		!ro_r ##1 ro_r;
	endsequence
	sequence s_four_stall;
		!ro_r [*4] ##1 ro_r;
	endsequence
	a_zero_ws_read: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ5]
		(ce_in && rd_av && !ws1 && !run) |=> ro_r && rd_r == $past(rd_word))
		else $error("zero wait read stalled");
	a_first_access_stall: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ8]
		(ce_in && rd_av && ws1 && !buf_hit && !run && hs_in.htrans == TR_NONSEQ) |=> s_one_stall)
		else $error("first access not stalled once");
	a_unaligned_second: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ9]
		(ce_in && rd_av && ws1 && !buf_hit && !run && hs_in.htrans == TR_SEQ && sec_r && unal_r) |=> !ro_r)
		else $error("unaligned second word not stalled");
	a_buffer_hit_fast: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ10]
		(ce_in && rd_av && buf_hit && !run) |=> ro_r && rd_r == $past(rd_word))
		else $error("buffer hit read stalled");
	a_pb_write_ws: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ20]
		(ce_in && wr_av) |=> s_four_stall)
		else $error("page buffer write wait count wrong");
	a_no_buf_zero_ws: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ11]
		(ce_in && !ws1) |=> !lastv_r && lval_r == '0)
		else $error("buffer tags kept in zero wait mode");
	// checks: page buffer, commands, gating
	a_buffer_and_only: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ21]
		(ce_in && pb_wr && dpa_r[2] && !run) |=> (pbuf_r[$past(pb_idx)] & ~$past(pbuf_r[pb_idx])) == 64'h0)
		else $error("page buffer write set a bit");
	a_flash_untouched: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ17]
		(ce_in && pb_wr && !run) |=> mem_r[$past(pbw_a)] == $past(mem_r[pbw_a]))
		else $error("page buffer write changed the array");
	a_user_check_fold: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ16]
		(ce_in && run && cmd_r == C_QUP && !(&up_r[cnt_r[BW-1:0]])) |=> !qacc_r && (!$past(done) || !qres_r))
		else $error("user page check missed a zero");
	a_ready_low_busy: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ24]
		run |-> !ready_r)
		else $error("ready high while a command runs");
	a_clock_gate_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ1]
		!ce_in |=> $stable(ro_r) && $stable(rd_r) && $stable(ctl_r) && $stable(cst_r) && $stable(cnt_r))
		else $error("state moved with clock enable low");
	a_busy_stall: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ23]
		(ce_in && run && dp_r && !dpw_r && !ro_r && wcnt_r == 3'h0) |=> !ro_r)
		else $error("read completed during command");
	a_cmd_clears_ready: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ24]
		(ce_in && cmd_wr) |=> !ready_r ##1 (!ready_r || $past(done)))
		else $error("ready not cleared by command write");
	a_ready_returns: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ24]
		(ce_in && done) |=> ready_r && !run)
		else $error("ready not set at completion");
	a_page_number: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ17]
		(ce_in && wr_av && !run && !cmd_wr) |=> page_r == $past(hs_in.haddr[AW+2:BW+3]))
		else $error("page field not loaded by buffer write");
	a_reset_config: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ25]
		$rose(ctl_r[CTL_SEQ]) |-> $past(pwr_r && pwa_r == REG_CTRL))
		else $error("buffer enabled without software write");
endmodule // frp_flash_ctl

// [verification/frp_hs_master.sv]
// Purpose: high-speed bus master model for the flash read path
// Assumes: AHB-Lite, incrementing word bursts, hready taken from the slave
// Notes: st and rd hold stall counts and read data of the last transfer
`timescale 1ns/1ns
module frp_hs_master (
	input wire logic clk_in,
	input wire frp_pkg::frp_ahb_rsp_s rsp_in,
	output frp_pkg::frp_ahb_req_s req_out
);
	import frp_pkg::*;
	int st[4];
	logic [31:0] rd[4];
	initial req_out = '0;
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input int n);
		int i;
		@(posedge clk_in);
		req_out.hsel <= 1'b1;
		req_out.htrans <= TR_NONSEQ;
		req_out.haddr <= a;
		req_out.hwrite <= w;
		req_out.hsize <= 3'h2; // whole aligned words only
		@(posedge clk_in);
		while (!rsp_in.hreadyout) @(posedge clk_in);
		for (i = 0; i < n; i++) begin
			req_out.hwdata <= d;
			req_out.htrans <= (i < n - 1) ? TR_SEQ : 2'h0;
			req_out.haddr <= a + 32'(4 * (i + 1));
			st[i] = 0;
			@(posedge clk_in);
			while (!rsp_in.hreadyout) begin
				st[i]++;
				@(posedge clk_in);
			end
			rd[i] = rsp_in.hrdata;
		end
		req_out.hsel <= 1'b0;
		req_out.hwdata <= ~d;
	endtask
endmodule // frp_hs_master

// [verification/frp_flash_ctl_tb.sv]
// Purpose: self-checking bench for the flash read path block
// Assumes: 100 MHz clock, reset held for five cycles
// Notes: high-speed traffic goes through the bus master model
`timescale 1ns/1ns
module frp_flash_ctl_tb;
	import frp_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic ce_in = 1'b1;
	frp_ahb_req_s hs_m, hs_q, pb_m, pb_q;
	frp_ahb_rsp_s hs_r, pb_r;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	int i;
	logic [31:0] q;
	always #5 clk_in = ~clk_in;
	always_comb begin
		hs_q = hs_m;
		hs_q.hready = hs_r.hreadyout;
		pb_q = pb_m;
		pb_q.hready = pb_r.hreadyout;
	end
	frp_flash_ctl #(.NUM_PAGES(16), .LOOP_ENT(4)) DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.hs_in(hs_q), .hs_out(hs_r), .pb_in(pb_q), .pb_out(pb_r));
	frp_hs_master M (.clk_in(clk_in), .rsp_in(hs_r), .req_out(hs_m));
	task automatic finish_test();
		$display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		pb_m.hsel <= 1'b1;
		pb_m.htrans <= TR_NONSEQ;
		pb_m.haddr <= {24'h0, a};
		pb_m.hwrite <= w;
		@(posedge clk_in);
		while (!pb_r.hreadyout) @(posedge clk_in);
		pb_m.htrans <= 2'h0;
		pb_m.hwdata <= d;
		@(posedge clk_in);
		while (!pb_r.hreadyout) @(posedge clk_in);
		q = pb_r.hrdata;
		pb_m.hwdata <= ~d;
	endtask
	task automatic wait_rdy();
		int k;
		for (k = 0; k < 2000; k++) begin
			pb(1'b0, REG_STAT, 32'h0);
			if (q[ST_RDY] === 1'b1) break;
		end
		chk({31'h0, q[ST_RDY]}, 32'h1);
	endtask
	task automatic cmd(input logic [3:0] c, input logic [3:0] pg);
		pb(1'b1, REG_CMD, {20'h0, pg, 4'h0, c});
		wait_rdy();
	endtask
	task automatic hr(input logic [31:0] a, input logic [31:0] e, input int s);
		M.xfer(1'b0, a, 32'h0, 1);
		chk(M.rd[0], e);
		chk(32'(M.st[0]), 32'(s));
		chk({31'h0, hs_r.hresp | pb_r.hresp}, 32'h0);
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		pb_m = '0;
		pb_m.hsize = 3'h2;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		pb(1'b0, REG_CTRL, 32'h0);
		chk(q, 32'h0);
		pb(1'b0, REG_STAT, 32'h0);
		chk({31'h0, q[ST_RDY]}, 32'h1);
		pb(1'b1, REG_CTRL, 32'h6);
		M.xfer(1'b0, 32'h4, 32'h0, 4);
		for (i = 0; i < 4; i++) begin
			chk(M.rd[i], 32'hffffffff);
			chk(32'(M.st[i]), 32'h0);
		end
		cmd(C_CLR_PB, 4'h0);
		M.xfer(1'b1, 32'h100, 32'h0f0f0f0f, 1);
		chk(32'(M.st[0]), 32'(WR_WS));
		M.xfer(1'b1, 32'h104, 32'hffffffff, 1);
		M.xfer(1'b1, 32'h100, 32'hffffffff, 1);
		M.xfer(1'b1, 32'h104, 32'hffff0000, 1);
		pb(1'b0, REG_CMD, 32'h0);
		chk({28'h0, q[11:8]}, 32'h1);
		hr(32'h100, 32'hffffffff, 0);
		pb(1'b1, REG_CMD, {20'h0, 4'h1, 4'h0, C_WR_PG});
		pb(1'b0, REG_STAT, 32'h0);
		chk({30'h0, q[ST_BUSY], q[ST_RDY]}, 32'h2);
		wait_rdy();
		M.xfer(1'b0, 32'h100, 32'h0, 2);
		chk(M.rd[0], 32'h0f0f0f0f);
		chk(M.rd[1], 32'hffff0000);
		cmd(C_WR_PG, 4'h2);
		hr(32'h200, 32'h0f0f0f0f, 0);
		cmd(C_QPG, 4'h1);
		chk({31'h0, q[ST_QRES]}, 32'h0);
		cmd(C_QPG, 4'h3);
		chk({31'h0, q[ST_QRES]}, 32'h1);
		cmd(C_QUP, 4'h0);
		chk({31'h0, q[ST_QRES]}, 32'h1);
		cmd(C_WR_UP, 4'h0);
		cmd(C_ER_ALL, 4'h0);
		hr(32'h00800000, 32'h0f0f0f0f, 0);
		hr(32'h200, 32'hffffffff, 0);
		cmd(C_QUP, 4'h0);
		chk({31'h0, q[ST_QRES]}, 32'h0);
		cmd(C_WR_PG, 4'h1);
		pb(1'b1, REG_CMD, {20'h0, 4'h1, 4'h0, C_ER_PG});
		M.xfer(1'b0, 32'h100, 32'h0, 1);
		chk({31'h0, M.st[0] > 4}, 32'h1);
		chk(M.rd[0], 32'hffffffff);
		pb(1'b1, REG_CTRL, 32'h1);
		M.xfer(1'b0, 32'h104, 32'h0, 3);
		chk(32'(M.st[0]), 32'h1);
		chk(32'(M.st[1]), 32'h1);
		chk(32'(M.st[2]), 32'h0);
		hr(32'h200, 32'hffffffff, 1);
		pb(1'b1, REG_CTRL, 32'h3);
		hr(32'h208, 32'hffffffff, 1);
		hr(32'h20c, 32'hffffffff, 0);
		pb(1'b1, REG_CTRL, 32'h5);
		hr(32'h300, 32'hffffffff, 1);
		hr(32'h300, 32'hffffffff, 0);
		ce_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		ce_in <= 1'b1;
		pb(1'b0, REG_CTRL, 32'h0);
		chk(q, 32'h5);
		finish_test();
	end
endmodule // frp_flash_ctl_tb
